// >>> common/fdc_cmd_pkg.sv
package fdc_cmd_pkg;

  // ----------------------------------------------------------------
  // command byte encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_ID_MASK    = 8'hbf;
  localparam logic [7:0] OP_READ_ID_VAL     = 8'h0a;
  localparam logic [7:0] OP_WRITE_MASK      = 8'h3f;
  localparam logic [7:0] OP_WRITE_VAL       = 8'h05;
  localparam logic [7:0] OP_WRITE_DEL_VAL   = 8'h09;
  localparam logic [7:0] OP_FORMAT_MASK     = 8'hbf;
  localparam logic [7:0] OP_FORMAT_VAL      = 8'h0d;
  localparam logic [7:0] OP_SCAN_MASK       = 8'h1f;
  localparam logic [7:0] OP_SCAN_EQ_VAL     = 8'h11;
  localparam logic [7:0] OP_SCAN_LE_VAL     = 8'h19;
  localparam logic [7:0] OP_SCAN_HE_VAL     = 8'h1d;
  localparam logic [7:0] OP_RECAL_VAL       = 8'h07;

  // ----------------------------------------------------------------
  // byte counts and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] LEN_READ_ID        = 4'h2;
  localparam logic [3:0] LEN_XFER           = 4'h9;
  localparam logic [3:0] LEN_FORMAT         = 4'h6;
  localparam logic [3:0] LEN_RECAL          = 4'h2;
  localparam logic [3:0] LEN_RESULT         = 4'h7;
  localparam logic [3:0] LEN_INVALID        = 4'h1;
  localparam int         BIT_MULTI          = 7;
  localparam int         BIT_DENSITY        = 6;
  localparam int         BIT_SKIP           = 5;
  localparam int         BIT_HEAD           = 2;
  localparam logic [6:0] RECAL_MAX_STEPS    = 7'h4d;
  localparam logic [7:0] ST0_EQUIP_CHECK    = 8'h10;
  localparam logic [7:0] ST0_ABRUPT         = 8'h40;
  localparam logic [7:0] ST0_INVALID        = 8'h80;
  localparam logic [7:0] ST0_SEEK_END       = 8'h20;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_READ_ID, CMD_WRITE, CMD_WRITE_DEL,
    CMD_FORMAT, CMD_SCAN, CMD_RECAL
  } cmd_kind_t;

  typedef enum logic [1:0] {
    SCAN_EQ, SCAN_LE, SCAN_HE
  } scan_mode_t;

  // decoded job handed to the drive engine
  typedef struct packed {
    cmd_kind_t  kind;
    scan_mode_t scan_mode;
    logic       multi_head_sel;
    logic       density_sel;
    logic       skip_deleted_sel;
    logic       head_number;
    logic [1:0] drive_sel;
    logic [7:0] cylinder;
    logic [7:0] head_addr;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] end_of_track;
    logic [7:0] gap_len;
    logic [7:0] last_param;
  } job_t;

  // status and position reported back by the engine
  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] cylinder;
    logic [7:0] head_addr;
    logic [7:0] sector;
    logic [7:0] size_code;
  } result_t;

endpackage

// >>> rtl/fdc_opcode_decode.sv
`timescale 1ns/1ps
module fdc_opcode_decode (
  input  wire logic [7:0]             i_op,
  output fdc_cmd_pkg::cmd_kind_t      o_kind,
  output fdc_cmd_pkg::scan_mode_t     o_scan_mode,
  output logic       [3:0]            o_len
);
  import fdc_cmd_pkg::*;

  always_comb begin
    o_kind      = CMD_NONE;
    o_scan_mode = SCAN_EQ;
    o_len       = LEN_INVALID;
    if ((i_op & OP_READ_ID_MASK) == OP_READ_ID_VAL) begin
      o_kind = CMD_READ_ID;
      o_len  = LEN_READ_ID;
    end else if ((i_op & OP_WRITE_MASK) == OP_WRITE_VAL) begin
      o_kind = CMD_WRITE;
      o_len  = LEN_XFER;
    end else if ((i_op & OP_WRITE_MASK) == OP_WRITE_DEL_VAL) begin
      o_kind = CMD_WRITE_DEL;
      o_len  = LEN_XFER;
    end else if ((i_op & OP_FORMAT_MASK) == OP_FORMAT_VAL) begin
      o_kind = CMD_FORMAT;
      o_len  = LEN_FORMAT;
    end else if ((i_op & OP_SCAN_MASK) == OP_SCAN_EQ_VAL) begin
      o_kind = CMD_SCAN;
      o_len  = LEN_XFER;
    end else if ((i_op & OP_SCAN_MASK) == OP_SCAN_LE_VAL) begin
      o_kind      = CMD_SCAN;
      o_scan_mode = SCAN_LE;
      o_len       = LEN_XFER;
    end else if ((i_op & OP_SCAN_MASK) == OP_SCAN_HE_VAL) begin
      o_kind      = CMD_SCAN;
      o_scan_mode = SCAN_HE;
      o_len       = LEN_XFER;
    end else if (i_op == OP_RECAL_VAL) begin
      o_kind = CMD_RECAL;
      o_len  = LEN_RECAL;
    end
  end

endmodule

// >>> rtl/fdc_cmd_seq.sv
`timescale 1ns/1ps
// How it works
// - read id: two bytes, density bit 6, low bits 1010, head and drive.
// - read id returns seven bytes: status, cylinder, head, sector, size.
// - write data: nine bytes, multi-head, density, low six bits 000101.
// - write data ends with the seven result bytes.
// - write deleted: same nine bytes, low six bits 001001.
// - write deleted ends with the seven result bytes.
// - format: six bytes, bit 7 zero, low bits 001101, then four params.
// - format ends with the seven result bytes.
// - scan equal: nine bytes, low bits 10001, last byte is scan test.
// - scan low or equal recognised by low bits 11001.
// - scan high or equal recognised by low bits 11101.
// - every scan ends with the seven result bytes in order.
// - recalibrate gives no result bytes; back to idle directly.
// - bit 5 of scan opcodes selects skipping deleted sectors.
// - density bit: 0 single density, 1 double density.
// - multi-head bit set: transfer continues onto second head.
// - recalibrate flags equipment check if no track zero after 77 steps.
module fdc_cmd_seq (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_cmd_valid,
  input  wire logic [7:0]            i_cmd_byte,
  output logic                       o_cmd_ready,
  input  wire logic                  i_res_take,
  output logic                       o_res_valid,
  output logic       [7:0]           o_res_byte,
  output fdc_cmd_pkg::job_t          o_job,
  output logic                       o_job_start,
  output logic                       o_mfm_mode,
  output logic                       o_second_head,
  input  wire logic                  i_job_done,
  input  wire fdc_cmd_pkg::result_t  i_result,
  input  wire logic                  i_head_end,
  output logic                       o_step,
  input  wire logic                  i_track0,
  output logic                       o_busy
);
  import fdc_cmd_pkg::*;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_PARAM, S_EXEC, S_RECAL, S_RESULT
  } seq_state_t;

  seq_state_t        state_q;
  cmd_kind_t         kind_q;
  scan_mode_t        scan_q;
  logic [3:0]        len_q;
  logic [3:0]        idx_q;
  logic [7:0]        prm_q [0:8];
  logic [7:0]        res_q [0:6];
  logic [3:0]        res_len_q;
  logic [6:0]        steps_q;
  logic [2:0]        t0_sync_q;
  logic              t0_q;
  logic              t0_s;
  cmd_kind_t         dec_kind;
  scan_mode_t        dec_scan;
  logic [3:0]        dec_len;
  logic              take_cmd;
  logic              take_res;
  logic              fixup;

  assign t0_s     = t0_sync_q[1];
  assign take_cmd = i_cmd_valid && o_cmd_ready;
  assign take_res = i_res_take && o_res_valid;
  assign fixup    = (state_q == S_PARAM) && (idx_q == len_q);

  fdc_opcode_decode u_dec (
    .i_op        (i_cmd_byte),
    .o_kind      (dec_kind),
    .o_scan_mode (dec_scan),
    .o_len       (dec_len)
  );

  // ----------------------------------------------------------------
  // track zero pin: three stages, change counts when last two agree
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      t0_sync_q <= 3'h0;
      t0_q      <= 1'b0;
    end else begin
      t0_sync_q <= {t0_sync_q[1:0], i_track0};
      // a level held for one cycle only never reaches t0_q
      if (t0_sync_q[2] == t0_s) begin
        t0_q <= t0_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // command and result sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= S_IDLE;
      kind_q    <= CMD_NONE;
      scan_q    <= SCAN_EQ;
      len_q     <= 4'h0;
      idx_q     <= 4'h0;
      res_len_q <= 4'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (take_cmd) begin
            kind_q <= dec_kind;
            scan_q <= dec_scan;
            len_q  <= dec_len;
            idx_q  <= 4'h1;
            if (dec_kind == CMD_NONE) begin
              // unknown opcode answers with one status byte
              res_len_q <= LEN_INVALID;
              idx_q     <= 4'h0;
              state_q   <= S_RESULT;
            end else begin
              state_q <= S_PARAM;
            end
          end
        end
        S_PARAM: begin
          if (fixup) begin
            state_q <= (kind_q == CMD_RECAL) ? S_RECAL : S_EXEC;
          end else if (take_cmd) begin
            idx_q <= idx_q + 4'h1;
          end
        end
        S_EXEC: begin
          if (i_job_done) begin
            res_len_q <= LEN_RESULT;
            idx_q     <= 4'h0;
            state_q   <= S_RESULT;
          end
        end
        S_RECAL: begin
          // no result phase; status left for a later sense command
          if (t0_q || steps_q == RECAL_MAX_STEPS) begin
            state_q <= S_IDLE;
          end
        end
        S_RESULT: begin
          if (take_res) begin
            if (idx_q == res_len_q - 4'h1) begin
              state_q <= S_IDLE;
            end
            idx_q <= idx_q + 4'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // parameter capture
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_prm
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          prm_q[g] <= 8'h00;
        end else if (take_cmd && !fixup &&
                     (state_q == S_PARAM ? idx_q == 4'(g) : g == 0)) begin
          prm_q[g] <= i_cmd_byte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // job and mode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_job         <= '0;
      o_job_start   <= 1'b0;
      o_mfm_mode    <= 1'b0;
      o_second_head <= 1'b0;
    end else begin
      o_job_start <= fixup && kind_q != CMD_RECAL;
      if (fixup) begin
        o_job.kind             <= kind_q;
        o_job.scan_mode        <= scan_q;
        o_job.multi_head_sel   <= prm_q[0][BIT_MULTI] &&
                                  kind_q != CMD_FORMAT &&
                                  kind_q != CMD_READ_ID;
        o_job.density_sel      <= prm_q[0][BIT_DENSITY] &&
                                  kind_q != CMD_RECAL;
        o_job.skip_deleted_sel <= prm_q[0][BIT_SKIP] &&
                                  kind_q == CMD_SCAN;
        o_job.head_number      <= prm_q[1][BIT_HEAD] &&
                                  kind_q != CMD_RECAL;
        o_job.drive_sel        <= prm_q[1][1:0];
        if (kind_q == CMD_FORMAT) begin
          // format carries size, count, gap, fill after the unit byte
          o_job.cylinder     <= 8'h00;
          o_job.head_addr    <= 8'h00;
          o_job.sector       <= 8'h00;
          o_job.size_code    <= prm_q[2];
          o_job.end_of_track <= prm_q[3];
          o_job.gap_len      <= prm_q[4];
          o_job.last_param   <= prm_q[5];
        end else begin
          o_job.cylinder     <= prm_q[2];
          o_job.head_addr    <= prm_q[3];
          o_job.sector       <= prm_q[4];
          o_job.size_code    <= prm_q[5];
          o_job.end_of_track <= prm_q[6];
          o_job.gap_len      <= prm_q[7];
          o_job.last_param   <= prm_q[8];
        end
        o_mfm_mode <= prm_q[0][BIT_DENSITY];
      end
      // second head taken on when first ends a multi-head pass
      if (fixup) begin
        o_second_head <= 1'b0;
      end else if (state_q == S_EXEC && i_head_end &&
                   o_job.multi_head_sel) begin
        o_second_head <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // recalibrate stepping
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      steps_q <= 7'h00;
      o_step  <= 1'b0;
    end else begin
      o_step <= 1'b0;
      if (fixup) begin
        steps_q <= 7'h00;
      end else if (state_q == S_RECAL && !t0_q &&
                   steps_q != RECAL_MAX_STEPS && !o_step) begin
        o_step  <= 1'b1;
        steps_q <= steps_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // result bytes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 7; k++) begin
        res_q[k] <= 8'h00;
      end
    end else if (state_q == S_IDLE && take_cmd && dec_kind == CMD_NONE) begin
      res_q[0] <= ST0_INVALID;
    end else if (state_q == S_EXEC && i_job_done) begin
      res_q[0] <= i_result.st0;
      res_q[1] <= i_result.st1;
      res_q[2] <= i_result.st2;
      res_q[3] <= i_result.cylinder;
      res_q[4] <= i_result.head_addr;
      res_q[5] <= i_result.sector;
      res_q[6] <= i_result.size_code;
    end else if (state_q == S_RECAL) begin
      if (t0_q) begin
        res_q[0] <= ST0_SEEK_END | {6'h00, prm_q[1][1:0]};
      end else if (steps_q == RECAL_MAX_STEPS) begin
        res_q[0] <= ST0_SEEK_END | ST0_ABRUPT | ST0_EQUIP_CHECK |
                    {6'h00, prm_q[1][1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // host handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_ready <= 1'b0;
      o_res_valid <= 1'b0;
      o_res_byte  <= 8'h00;
      o_busy      <= 1'b0;
    end else begin
      o_busy      <= state_q != S_IDLE;
      o_cmd_ready <= (state_q == S_IDLE && !take_cmd) ||
                     (state_q == S_PARAM && !fixup &&
                      !(take_cmd && idx_q == len_q - 4'h1));
      o_res_valid <= state_q == S_RESULT &&
                     !(take_res && idx_q == res_len_q - 4'h1) &&
                     !take_res;
      // idx runs past the last slot once the phase ends
      if (state_q == S_RESULT) begin
        o_res_byte <= res_q[3'(idx_q)];
      end
    end
  end

endmodule

// >>> testbench/fdc_cmd_seq_props.sv
`timescale 1ns/1ps
module fdc_cmd_seq_props (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       o_cmd_ready,
  input wire logic       i_res_take,
  input wire logic       o_res_valid,
  input wire logic [7:0] o_res_byte,
  input wire logic       o_job_start,
  input wire logic       i_job_done,
  input wire logic       o_step,
  input wire logic       i_track0
);
  logic [6:0] steps_q;

  // ----------------------------------------------------------------
  // step tally, cleared while commands are accepted
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      steps_q <= 7'h00;
    end else if (o_cmd_ready) begin
      steps_q <= 7'h00;
    end else if (o_step) begin
      steps_q <= steps_q + 7'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_take_drops: assert property (
    o_res_valid && i_res_take |=> !o_res_valid)
    else $error("result valid held after take");
  a_res_hold: assert property (o_res_valid && !i_res_take |=>
    o_res_valid && $stable(o_res_byte))
    else $error("result byte moved before take");
  a_done_res: assert property (i_job_done |-> ##[1:3] o_res_valid)
    else $error("no result after job done");
  a_res_refuse: assert property (o_res_valid |-> !o_cmd_ready)
    else $error("command accepted during result phase");
  a_start_pulse: assert property (o_job_start |=> !o_job_start)
    else $error("job start longer than one cycle");
  a_step_pulse: assert property (o_step |=> !o_step)
    else $error("step pulses back to back");
  a_step_limit: assert property (steps_q <= 7'h4d)
    else $error("more than the step limit issued");
  a_recal_quiet: assert property (o_step |-> !o_res_valid)
    else $error("result offered during recalibrate");
  a_track_stop: assert property (i_track0 [*6] |-> !o_step)
    else $error("stepping after track zero seen");
endmodule

bind fdc_cmd_seq fdc_cmd_seq_props u_props (
  .i_clk       (i_clk),
  .i_rst       (i_rst),
  .o_cmd_ready (o_cmd_ready),
  .i_res_take  (i_res_take),
  .o_res_valid (o_res_valid),
  .o_res_byte  (o_res_byte),
  .o_job_start (o_job_start),
  .i_job_done  (i_job_done),
  .o_step      (o_step),
  .i_track0    (i_track0)
);

// >>> testbench/fdc_engine_model.sv
`timescale 1ns/1ps
module fdc_engine_model (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_job_start,
  input  wire fdc_cmd_pkg::job_t   i_job,
  output logic                     o_job_done = 1'b0,
  output logic                     o_head_end = 1'b0,
  output fdc_cmd_pkg::result_t     o_result = '0
);
  import fdc_cmd_pkg::*;
  int cnt = 0;

  // ----------------------------------------------------------------
  // drive engine stand-in, reacts on the falling edge
  // ----------------------------------------------------------------
  always @(negedge i_clk) begin
    o_job_done = 1'b0;
    o_head_end = 1'b0;
    o_result = ~o_result;
    if (i_rst) begin
      cnt = 0;
    end else begin
      // recalibrate never reports through the result path
      if (i_job_start && i_job.kind != CMD_RECAL) begin
        cnt = 8;
      end else if (cnt > 0) begin
        cnt--;
      end
      if (cnt == 4) begin
        // pulsed for every job so single-head runs prove the gating
        o_head_end = 1'b1;
      end
      if (cnt == 1) begin
        o_job_done = 1'b1;
        o_result = {6'h00, i_job.drive_sel,
                    48'h112233445566};
      end
    end
  end
endmodule

// >>> testbench/tb_fdc_cmd_seq.sv
`timescale 1ns/1ps
module tb_fdc_cmd_seq;
  import fdc_cmd_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic       res_take = 1'b0;
  logic       track0 = 1'b0;
  logic       cmd_ready, res_valid, job_start, mfm_mode, second_head;
  logic       job_done, head_end, step, busy;
  logic [7:0] res_byte;
  job_t       job;
  result_t    result;
  int         n_fail = 0;
  int         n_compared = 0;
  int         n_steps = 0;
  logic [7:0] xp [8] = '{8'h06, 8'h12, 8'h01, 8'h03, 8'h02, 8'h09,
                         8'h1b, 8'hff};

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (step === 1'b1) begin
      n_steps++;
    end
  end

  fdc_cmd_seq uut (
    .i_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid),
    .i_cmd_byte(cmd_byte), .o_cmd_ready(cmd_ready),
    .i_res_take(res_take), .o_res_valid(res_valid),
    .o_res_byte(res_byte), .o_job(job), .o_job_start(job_start),
    .o_mfm_mode(mfm_mode), .o_second_head(second_head),
    .i_job_done(job_done), .i_result(result), .i_head_end(head_end),
    .o_step(step), .i_track0(track0), .o_busy(busy)
  );
  fdc_engine_model engine (
    .i_clk(clk), .i_rst(rst), .i_job_start(job_start), .i_job(job),
    .o_job_done(job_done), .o_head_end(head_end), .o_result(result)
  );

  // ----------------------------------------------------------------
  // host side helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    while (cmd_ready !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk("cmd ready", 8'h01, {7'h00, cmd_ready});
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wait_start();
    int k;
    k = 0;
    while (job_start !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk("job start", 8'h01, {7'h00, job_start});
  endtask

  task automatic get_res(input logic [55:0] exp, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (res_valid !== 1'b1 && k < 50) begin
        @(negedge clk);
        k++;
      end
      chk("result valid", 8'h01, {7'h00, res_valid});
      chk("result byte", exp[55-8*i -: 8], res_byte);
      res_take = 1'b1;
      @(negedge clk);
      res_take = 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_read_id();
    send(8'h4a);
    send(8'h05);
    wait_start();
    chk("read id job", {CMD_READ_ID, 5'h0d},
        {job.kind, job.multi_head_sel, job.density_sel,
         job.head_number, job.drive_sel});
    get_res({8'h01, 48'h112233445566}, 7);
    chk("mfm mode", 8'h01, {7'h00, mfm_mode});
    $display("read id finished");
  endtask

  task automatic t_xfer(input logic [7:0] op, input cmd_kind_t kd,
                        input scan_mode_t sm);
    send(op);
    for (int i = 0; i < 8; i++) begin
      send(xp[i]);
    end
    wait_start();
    chk("xfer job", {kd, op[7:6], 3'h6}, {job.kind,
        job.multi_head_sel, job.density_sel, job.head_number,
        job.drive_sel});
    chk("cylinder", 8'h12, job.cylinder);
    chk("head addr", 8'h01, job.head_addr);
    chk("sector", 8'h03, job.sector);
    chk("size code", 8'h02, job.size_code);
    chk("end of track", 8'h09, job.end_of_track);
    chk("gap", 8'h1b, job.gap_len);
    chk("last param", 8'hff, job.last_param);
    if (kd == CMD_SCAN) begin
      chk("scan mode", {5'h00, op[5], sm},
          {5'h00, job.skip_deleted_sel, job.scan_mode});
    end
    get_res({8'h02, 48'h112233445566}, 7);
    chk("second head", {7'h00, op[7]}, {7'h00, second_head});
    chk("mfm mode", {7'h00, op[6]}, {7'h00, mfm_mode});
    $display("transfer %h finished", op);
  endtask

  task automatic t_format();
    send(8'h4d);
    send(8'h05);
    send(8'h02);
    send(8'h12);
    send(8'h1b);
    send(8'he5);
    wait_start();
    chk("format job", {CMD_FORMAT, 5'h0d},
        {job.kind, job.multi_head_sel, job.density_sel,
         job.head_number, job.drive_sel});
    chk("size", 8'h02, job.size_code);
    chk("count", 8'h12, job.end_of_track);
    chk("gap", 8'h1b, job.gap_len);
    chk("fill", 8'he5, job.last_param);
    get_res({8'h01, 48'h112233445566}, 7);
    $display("format finished");
  endtask

  task automatic t_recal(input int stop_at);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    n_steps = 0;
    send(8'h07);
    send(8'h02);
    chk("recal busy", 8'h01, {7'h00, busy});
    while (cmd_ready !== 1'b1 && k < 400) begin
      if (res_valid === 1'b1) begin
        seen = 1'b1;
      end
      if (n_steps >= stop_at) begin
        track0 = 1'b1;
      end
      @(negedge clk);
      k++;
    end
    chk("recal idle", 8'h00, {7'h00, busy});
    chk("recal result", 8'h00, {7'h00, seen});
    if (stop_at > 77) begin
      chk("step count", 8'h4d, n_steps[7:0]);
    end else begin
      chk("short recal", 8'h01, {7'h00, n_steps < 77});
    end
    track0 = 1'b0;
    $display("recalibrate finished");
  endtask

  task automatic t_invalid();
    send(8'h1f);
    get_res({8'h80, 48'h000000000000}, 1);
    $display("invalid opcode finished");
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_read_id();
    t_xfer(8'hc5, CMD_WRITE, SCAN_EQ);
    t_xfer(8'h09, CMD_WRITE_DEL, SCAN_EQ);
    t_xfer(8'hf1, CMD_SCAN, SCAN_EQ);
    t_xfer(8'h19, CMD_SCAN, SCAN_LE);
    t_xfer(8'h7d, CMD_SCAN, SCAN_HE);
    t_format();
    t_recal(1000);
    t_recal(10);
    t_invalid();
    close_out();
  end
endmodule
